// ---- src/sci_baud_gen.sv ----
// Purpose: Baud divider producing sixteen sample ticks per bit
// Assumes: srcTick already reflects the chosen source clock
// Notes:   Divider restarts cleanly only at its own wrap points

`timescale 1ns/1ps

module sci_baud_gen (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       srcTick,
	input  wire logic [1:0] prescalerCode,
	input  wire logic [2:0] rateDivisorCode,
	output logic            sampleTick
);

	typedef struct packed {
		logic [3:0] preCnt;
		logic [6:0] rateCnt;
		logic       tick;
	} baud_state_type;

	baud_state_type s;
	baud_state_type next_s;
	logic [3:0]     prescalerDivisor;
	logic [6:0]     rateDivisorLast;

	// ************************************************************
	// Divisor decode
	// ************************************************************
	always_comb begin
		case (prescalerCode)
			2'h0: prescalerDivisor = sci_rx_pkg::PD_CODE0; // see RULE14
			2'h1: prescalerDivisor = sci_rx_pkg::PD_CODE1;
			2'h2: prescalerDivisor = sci_rx_pkg::PD_CODE2;
			default: prescalerDivisor = sci_rx_pkg::PD_CODE3;
		endcase
		rateDivisorLast = 7'((8'h01 << rateDivisorCode) - 8'h01); // see RULE15
	end

	// ************************************************************
	// Cascaded counters
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (srcTick) begin
			if (s.preCnt >= prescalerDivisor - 4'h1) begin
				next_s.preCnt = 4'h0;
				if (s.rateCnt >= rateDivisorLast) begin
					next_s.rateCnt = 7'h00;
					next_s.tick = 1'b1; // see RULE16 see RULE17
				end else begin
					next_s.rateCnt = s.rateCnt + 7'h01;
				end
			end else begin
				next_s.preCnt = s.preCnt + 4'h1;
			end
		end
		if (sys_rst) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= next_s;
	end

	assign sampleTick = s.tick;

	// Fastest setting passes every source tick straight through
	tick_rate_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE16
		(srcTick && prescalerCode == 2'h0 && rateDivisorCode == 3'h0 && !$past(sys_rst))
		|=> sampleTick)
		else $error("sample tick missing at divide by one");

endmodule : sci_baud_gen

// ---- src/sci_rx_flags.sv ----
// Purpose: Receive flags, data buffer and baud rate control of a serial port
// Assumes: Receive line and oscillator enable are synchronous to clk_sys
// Notes:   Single sample per bit at mid slot; no noise voting
//
// The strobed register port is this design's own decision.

`timescale 1ns/1ps

// Function
// RULE1 - Stop bit sampled low sets framing error; error irq when its enable set
// RULE2 - Framing error clears by status one read with flag set, then data read
// RULE3 - Parity mismatch sets parity error; error irq when its enable set
// RULE4 - Parity error clears by status one read with flag set, then data read
// RULE5 - Break sets break flag plus framing error and receiver full
// RULE6 - Break in nine-bit mode clears received ninth bit
// RULE7 - Break flag never interrupts; clears by status two read then data read
// RULE8 - Break flag sets again only after line shows ones, then a new break
// RULE9 - Low at first sample slot of start search sets reception in progress
// RULE10 - Reception in progress clears on false start or idle character
// RULE11 - Data read gives received byte, write loads transmit byte, reset keeps it
// RULE12 - Software avoids read-modify-write on the data buffer
// RULE13 - Source select one picks bus clock, zero oscillator; reset clears
// RULE14 - Prescaler code picks divisor 1, 3, 4 or 13; reset clears
// RULE15 - Rate code picks divisor two to the code; reset clears
// RULE16 - Bit rate is source over sixteen times both divisors, shared both ways
// RULE17 - Baud generator gives sixteen sample ticks per bit for the receiver
module sci_rx_flags (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrEn,
	input  wire logic       rdEn,
	input  wire logic       rxLine,
	input  wire logic       oscillatorTick,
	output logic      [7:0] rdData,
	output logic      [7:0] txData,
	output logic            txLoad,
	output logic            irq,
	output logic            errorIrq
);

	typedef struct packed {
		sci_rx_pkg::rx_state_type rxState;
		logic [3:0] tickCnt;
		logic [3:0] bitCnt;
		logic [8:0] shift;
		logic       allZero;
		logic       parAcc;
		logic       parBad;
		logic [7:0] idleCnt;
		logic       fe;
		logic       pe;
		logic       receiver_full_flag;
		logic       break_detected_flag;
		logic       reception_in_progress_flag;
		logic       r8;
		logic       breakArm;
		logic       armFe;
		logic       armPe;
		logic       armScrf;
		logic       armBk;
		logic [7:0] rxData;
		logic [7:0] txData;
		logic       txLoad;
		logic       baud_source_select;
		logic [1:0] pcode;
		logic [2:0] rcode;
		logic       framing_error_irq_enable;
		logic       parity_error_irq_enable;
		logic       rxEn;
		logic       nineBit;
		logic       parEn;
		logic       parOdd;
		logic [sci_rx_pkg::IQ_BITS-1:0] sticky;
		logic [sci_rx_pkg::IQ_BITS-1:0] mask;
		logic [7:0] rdData;
		logic       irq;
		logic       errorIrq;
	} rx_flags_state_type;

	rx_flags_state_type s;
	rx_flags_state_type next_s;
	logic               sampleTick;
	logic               srcTick;
	logic [3:0]         cnt;
	logic               atMid;
	logic               atEnd;
	logic [7:0]         statusOne;
	logic [7:0]         statusTwo;
	logic               dataRead;

	// ************************************************************
	// Baud generator
	// ************************************************************
	assign srcTick = s.baud_source_select ? 1'b1 : oscillatorTick; // see RULE13

	sci_baud_gen baudGen (
		.clk_sys         (clk_sys),
		.sys_rst         (sys_rst),
		.srcTick         (srcTick),
		.prescalerCode   (s.pcode),
		.rateDivisorCode (s.rcode),
		.sampleTick      (sampleTick)
	);

	// ************************************************************
	// Status views
	// ************************************************************
	always_comb begin
		statusOne = 8'h00;
		statusOne[sci_rx_pkg::S1_RECEIVER_FULL_FLAG] = s.receiver_full_flag;
		statusOne[sci_rx_pkg::S1_FE] = s.fe;
		statusOne[sci_rx_pkg::S1_PE] = s.pe;
		statusTwo = 8'h00;
		statusTwo[sci_rx_pkg::S2_BKF] = s.break_detected_flag;
		statusTwo[sci_rx_pkg::S2_RPF] = s.reception_in_progress_flag;
		cnt = s.tickCnt + 4'h1;
		atMid = sampleTick && cnt == sci_rx_pkg::MID_SLOT;
		atEnd = sampleTick && s.tickCnt == sci_rx_pkg::LAST_SLOT;
		dataRead = rdEn && regAddr == sci_rx_pkg::ADDR_DATA_BUF;
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.txLoad = 1'b0;
		next_s.rdData = 8'h00;

		// Register port; clears come before receive sets so a set wins
		if (rdEn) begin
			case (regAddr)
				sci_rx_pkg::ADDR_STATUS_ONE: begin
					next_s.rdData = statusOne;
					next_s.armFe = s.fe; // see RULE2
					next_s.armPe = s.pe; // see RULE4
					next_s.armScrf = s.receiver_full_flag;
				end
				sci_rx_pkg::ADDR_STATUS_TWO: begin
					next_s.rdData = statusTwo;
					next_s.armBk = s.break_detected_flag; // see RULE7
				end
				sci_rx_pkg::ADDR_DATA_BUF: begin
					next_s.rdData = s.rxData; // see RULE11
					next_s.fe = s.fe && !s.armFe; // see RULE2
					next_s.pe = s.pe && !s.armPe; // see RULE4
					next_s.receiver_full_flag = s.receiver_full_flag && !s.armScrf;
					next_s.break_detected_flag = s.break_detected_flag && !s.armBk; // see RULE7
					next_s.armFe = 1'b0;
					next_s.armPe = 1'b0;
					next_s.armScrf = 1'b0;
					next_s.armBk = 1'b0;
				end
				sci_rx_pkg::ADDR_CONTROL_THR: begin
					next_s.rdData = {s.r8, 5'h00, s.framing_error_irq_enable, s.parity_error_irq_enable};
				end
				sci_rx_pkg::ADDR_RATE_SELECT: begin
					next_s.rdData = {2'h0, s.baud_source_select, s.pcode, s.rcode};
				end
				sci_rx_pkg::ADDR_RX_CONFIG: begin
					next_s.rdData = {4'h0, s.parOdd, s.parEn, s.nineBit, s.rxEn};
				end
				sci_rx_pkg::ADDR_IRQ_STATUS: next_s.rdData = {5'h00, s.sticky};
				sci_rx_pkg::ADDR_IRQ_MASK: next_s.rdData = {5'h00, s.mask};
				default: next_s.rdData = 8'h00;
			endcase
		end
		if (wrEn) begin
			case (regAddr)
				sci_rx_pkg::ADDR_DATA_BUF: begin
					next_s.txData = wrData; // see RULE11
					next_s.txLoad = 1'b1;
				end
				sci_rx_pkg::ADDR_CONTROL_THR: begin
					next_s.framing_error_irq_enable = wrData[sci_rx_pkg::C3_FRAMING_ERROR_IRQ_ENABLE];
					next_s.parity_error_irq_enable = wrData[sci_rx_pkg::C3_PARITY_ERROR_IRQ_ENABLE];
				end
				sci_rx_pkg::ADDR_RATE_SELECT: begin
					next_s.baud_source_select = wrData[sci_rx_pkg::RS_CKS]; // see RULE13
					next_s.pcode = wrData[sci_rx_pkg::RS_SCP +: 2]; // see RULE14
					next_s.rcode = wrData[sci_rx_pkg::RS_SCR +: 3]; // see RULE15
				end
				sci_rx_pkg::ADDR_RX_CONFIG: begin
					next_s.rxEn = wrData[sci_rx_pkg::CF_EN];
					next_s.nineBit = wrData[sci_rx_pkg::CF_NINE];
					next_s.parEn = wrData[sci_rx_pkg::CF_PAR];
					next_s.parOdd = wrData[sci_rx_pkg::CF_ODD];
				end
				sci_rx_pkg::ADDR_IRQ_STATUS: begin
					next_s.sticky = s.sticky & ~wrData[sci_rx_pkg::IQ_BITS-1:0];
				end
				sci_rx_pkg::ADDR_IRQ_MASK: next_s.mask = wrData[sci_rx_pkg::IQ_BITS-1:0];
				default: begin
				end
			endcase
		end

		// Receiver, paced by sixteenth-bit ticks
		if (sampleTick && s.rxEn) begin
			next_s.tickCnt = cnt;
			case (s.rxState)
				sci_rx_pkg::RX_IDLE: begin
					next_s.tickCnt = 4'h0;
					if (!rxLine) begin
						next_s.reception_in_progress_flag = 1'b1; // see RULE9
						next_s.rxState = sci_rx_pkg::RX_START;
						next_s.idleCnt = 8'h00;
					end else begin
						next_s.breakArm = 1'b1; // see RULE8
						if (s.idleCnt == sci_rx_pkg::IDLE_TICKS - 8'h01) begin
							next_s.reception_in_progress_flag = 1'b0; // see RULE10
						end
						if (s.idleCnt != sci_rx_pkg::IDLE_TICKS) begin
							next_s.idleCnt = s.idleCnt + 8'h01;
						end
					end
				end
				sci_rx_pkg::RX_START: begin
					if (atMid && rxLine) begin
						next_s.reception_in_progress_flag = 1'b0; // see RULE10
						next_s.rxState = sci_rx_pkg::RX_IDLE;
					end else if (atEnd) begin
						next_s.rxState = sci_rx_pkg::RX_DATA;
						next_s.bitCnt = 4'h0;
						next_s.allZero = 1'b1;
						next_s.parAcc = 1'b0;
					end
				end
				sci_rx_pkg::RX_DATA: begin
					if (atMid) begin
						next_s.shift = {rxLine, s.shift[8:1]};
						next_s.allZero = s.allZero && !rxLine;
						next_s.parAcc = s.parAcc ^ rxLine;
					end
					if (atEnd) begin
						next_s.bitCnt = s.bitCnt + 4'h1;
						if (s.bitCnt == (s.nineBit ? sci_rx_pkg::BITS_NINE
						                           : sci_rx_pkg::BITS_EIGHT)) begin
							next_s.rxState = s.parEn ? sci_rx_pkg::RX_PARITY
							                         : sci_rx_pkg::RX_STOP;
						end
					end
				end
				sci_rx_pkg::RX_PARITY: begin
					if (atMid) begin
						next_s.allZero = s.allZero && !rxLine;
						next_s.parBad = s.parAcc ^ rxLine ^ s.parOdd; // see RULE3
					end
					if (atEnd) begin
						next_s.rxState = sci_rx_pkg::RX_STOP;
					end
				end
				sci_rx_pkg::RX_STOP: begin
					if (atMid) begin
						next_s.rxState = sci_rx_pkg::RX_IDLE;
						next_s.rxData = s.nineBit ? s.shift[7:0] : s.shift[8:1];
						next_s.r8 = s.shift[8];
						next_s.receiver_full_flag = 1'b1;
						next_s.sticky[sci_rx_pkg::IQ_RX] = 1'b1;
						if (s.parEn && s.parBad) begin
							next_s.pe = 1'b1; // see RULE3
							next_s.sticky[sci_rx_pkg::IQ_PE] = 1'b1;
						end
						if (!rxLine) begin
							next_s.fe = 1'b1; // see RULE1 see RULE5
							next_s.sticky[sci_rx_pkg::IQ_FE] = 1'b1;
						end
						// A held-low line repeats zero frames; only a fresh break flags
						if (!rxLine && s.allZero && s.breakArm) begin
							next_s.break_detected_flag = 1'b1; // see RULE5 see RULE8
							next_s.breakArm = 1'b0;
							next_s.pe = 1'b0;
							if (s.nineBit) begin
								next_s.r8 = 1'b0; // see RULE6
							end
						end
					end
				end
				default: next_s.rxState = sci_rx_pkg::RX_IDLE;
			endcase
		end

		// Break flag feeds no interrupt path
		next_s.errorIrq = (next_s.fe && next_s.framing_error_irq_enable) || (next_s.pe && next_s.parity_error_irq_enable); // see RULE1 see RULE3 see RULE7
		next_s.irq = |(next_s.sticky & next_s.mask);

		if (sys_rst) begin
			next_s = '0;
			next_s.rxState = sci_rx_pkg::RX_IDLE;
			next_s.rxData = s.rxData; // see RULE11
			next_s.txData = s.txData;
			next_s.r8 = s.r8;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= next_s;
	end

	assign rdData = s.rdData;
	assign txData = s.txData;
	assign txLoad = s.txLoad;
	assign irq = s.irq;
	assign errorIrq = s.errorIrq;

	// ************************************************************
	// Checks
	// ************************************************************
	stop_framing_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE1
		(s.rxEn && s.rxState == sci_rx_pkg::RX_STOP && atMid && !rxLine) |=> s.fe)
		else $error("low stop bit did not set framing error");

	error_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE3
		(s.pe && s.parity_error_irq_enable && !$past(sys_rst)) |-> errorIrq)
		else $error("parity error with enable gave no error irq");

	fe_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE2
		$fell(s.fe) |-> $past(dataRead && s.armFe))
		else $error("framing error cleared without sequence");

	pe_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE4
		$fell(s.pe) |-> $past(dataRead && s.armPe) || $rose(s.break_detected_flag))
		else $error("parity error cleared without sequence");

	break_flags_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE5
		$rose(s.break_detected_flag) |-> s.fe && s.receiver_full_flag)
		else $error("break without framing and full flags");

	break_ninth_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE6
		($rose(s.break_detected_flag) && s.nineBit) |-> !s.r8)
		else $error("break left ninth bit set");

	bkf_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE7
		$fell(s.break_detected_flag) |-> $past(dataRead && s.armBk))
		else $error("break flag cleared without sequence");

	break_rearm_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE8
		$rose(s.break_detected_flag) |-> $past(s.breakArm))
		else $error("break flag set without line high first");

	rpf_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE9
		(sampleTick && s.rxEn && s.rxState == sci_rx_pkg::RX_IDLE && !rxLine) |=> s.reception_in_progress_flag)
		else $error("start search zero did not set progress flag");

	rpf_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE10
		$fell(s.reception_in_progress_flag) |-> $past(s.rxState == sci_rx_pkg::RX_START
		                       || s.idleCnt == sci_rx_pkg::IDLE_TICKS - 8'h01))
		else $error("progress flag cleared without cause");

	read_data_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE11
		dataRead |=> rdData == $past(s.rxData))
		else $error("data read returned wrong byte");

	rate_reset_a: assert property (@(posedge clk_sys) // see RULE13 see RULE14 see RULE15
		$fell(sys_rst) |-> !s.baud_source_select && s.pcode == 2'h0 && s.rcode == 3'h0)
		else $error("rate select not cleared by reset");

endmodule : sci_rx_flags

// ---- src/sci_rx_pkg.sv ----
// Purpose: Shared constants for the serial receive flags and baud generator
// Assumes: Byte-wide register port, one system clock
// Notes:   Oscillator clock arrives as a one-cycle enable pulse

package sci_rx_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_STATUS_ONE  = 8'h40;
	localparam logic [7:0] ADDR_STATUS_TWO  = 8'h41;
	localparam logic [7:0] ADDR_CONTROL_THR = 8'h44;
	localparam logic [7:0] ADDR_DATA_BUF    = 8'h45;
	localparam logic [7:0] ADDR_RATE_SELECT = 8'h46;
	localparam logic [7:0] ADDR_RX_CONFIG   = 8'h47;
	localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h48;
	localparam logic [7:0] ADDR_IRQ_MASK    = 8'h49;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int S1_RECEIVER_FULL_FLAG = 5;
	localparam int S1_FE   = 1;
	localparam int S1_PE   = 0;
	localparam int S2_BKF  = 1;
	localparam int S2_RPF  = 0;
	localparam int C3_R8   = 7;
	localparam int C3_FRAMING_ERROR_IRQ_ENABLE = 1;
	localparam int C3_PARITY_ERROR_IRQ_ENABLE = 0;
	localparam int RS_CKS  = 5;
	localparam int RS_SCP  = 3;
	localparam int RS_SCR  = 0;
	localparam int CF_EN   = 0;
	localparam int CF_NINE = 1;
	localparam int CF_PAR  = 2;
	localparam int CF_ODD  = 3;
	localparam int IQ_RX   = 0;
	localparam int IQ_FE   = 1;
	localparam int IQ_PE   = 2;
	localparam int IQ_BITS = 3;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam logic [3:0] MID_SLOT    = 4'h7;
	localparam logic [3:0] LAST_SLOT   = 4'hF;
	localparam logic [3:0] BITS_EIGHT  = 4'h7;
	localparam logic [3:0] BITS_NINE   = 4'h8;
	localparam logic [7:0] IDLE_TICKS  = 8'hA0;
	localparam logic [3:0] PD_CODE0    = 4'h1;
	localparam logic [3:0] PD_CODE1    = 4'h3;
	localparam logic [3:0] PD_CODE2    = 4'h4;
	localparam logic [3:0] PD_CODE3    = 4'hD;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;

endpackage : sci_rx_pkg

// ---- testbench/sci_line_model.sv ----
// Purpose: Remote serial sender that drives the receive line
// Assumes: Bit period is given in system clock cycles
// Notes:   Line idles high and only changes when a task asks

`timescale 1ns/1ps

module sci_line_model (
	input  wire logic clk_sys,
	output logic      rxLine
);
	// ********************
	// Line driver
	// ********************
	initial rxLine = 1'b1;

	// Frame bits leave LSB first, start bit in bit 0; the last bit's level stays
	task automatic send(input logic [11:0] bits, input int n, input int cyc);
		for (int i = 0; i < n; i++) begin
			rxLine <= bits[i];
			repeat (cyc) @(posedge clk_sys);
		end
	endtask : send

	// Level stays after the task, so breaks can run across bus accesses
	task automatic hold(input logic lvl, input int cyc);
		rxLine <= lvl;
		repeat (cyc) @(posedge clk_sys);
	endtask : hold
endmodule : sci_line_model

// ---- testbench/sci_rx_flags_and_baud_gen_bench.sv ----
// Purpose: Self-checking bench for receive flags, data buffer and baud rate
// Assumes: Oscillator enable toggles every cycle, so it pulses every other cycle
// Notes:   Rate codes 0 with bus clock give one sample tick per cycle

`timescale 1ns/1ps

`define CHK(got, exp) begin \
	nTests++; \
	if ((got) !== (exp)) begin \
		errCount++; \
		$display("mismatch at %0t: got %h expected %h", $time, got, exp); \
	end \
end

module sci_rx_flags_and_baud_gen_bench;
	logic       clk_sys, sys_rst, wrEn, rdEn, rxLine, oscillatorTick;
	logic [7:0] regAddr, wrData, rdData, txData;
	logic       txLoad, irq, errorIrq;
	int         errCount, nTests;

	// ********************
	// Clock, stimulus and instances
	// ********************
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial oscillatorTick = 1'b0;
	always @(posedge clk_sys) oscillatorTick <= ~oscillatorTick;

	sci_line_model line (.clk_sys(clk_sys), .rxLine(rxLine));

	sci_rx_flags dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .wrData(wrData),
		.wrEn(wrEn), .rdEn(rdEn), .rxLine(rxLine), .oscillatorTick(oscillatorTick),
		.rdData(rdData), .txData(txData), .txLoad(txLoad), .irq(irq),
		.errorIrq(errorIrq)
	);

	// ********************
	// Bus tasks
	// ********************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clk_sys);
		wrEn <= 1'b0;
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		rdEn <= 1'b1;
		@(posedge clk_sys);
		rdEn <= 1'b0;
		#1;
		`CHK(rdData, e)
	endtask : rc

	task automatic settle;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle

	task automatic completeRun;
		$display("Checks: %0d, mismatches: %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : completeRun

	// ********************
	// Scenarios
	// ********************
	task automatic scnReset;
		rc(sci_rx_pkg::ADDR_RATE_SELECT, 8'h00);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h00);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h00);
		rc(8'h4F, 8'h00);
		wr(sci_rx_pkg::ADDR_RATE_SELECT, 8'h3F);
		rc(sci_rx_pkg::ADDR_RATE_SELECT, 8'h3F);
	endtask : scnReset

	task automatic scnTx;
		// Buffer only ever written whole, never read back and modified
		wr(sci_rx_pkg::ADDR_DATA_BUF, 8'hA5);
		#1;
		`CHK({txLoad, txData}, 9'h1A5)
		@(posedge clk_sys);
		#1;
		`CHK(txLoad, 1'b0)
	endtask : scnTx

	task automatic scnGood;
		wr(sci_rx_pkg::ADDR_RX_CONFIG, 8'h01);
		wr(sci_rx_pkg::ADDR_RATE_SELECT, 8'h20);
		line.send({1'b1, 8'h5A, 1'b0}, 10, 16);
		settle();
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h01);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h20);
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'h5A);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h00);
		`CHK(irq, 1'b0)
		wr(sci_rx_pkg::ADDR_IRQ_MASK, 8'h01);
		settle();
		`CHK(irq, 1'b1)
		wr(sci_rx_pkg::ADDR_IRQ_STATUS, 8'h01);
		settle();
		`CHK(irq, 1'b0)
		wr(sci_rx_pkg::ADDR_IRQ_MASK, 8'h00);
		line.hold(1'b1, 170);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h00);
		// False start: low only briefly, high again before the mid check
		line.hold(1'b0, 3);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h01);
		line.hold(1'b1, 20);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h00);
	endtask : scnGood

	task automatic scnFrame;
		wr(sci_rx_pkg::ADDR_CONTROL_THR, 8'h02);
		// Low stop held one cycle past its sample, so the next start check sees a low line and takes a false start
		line.send({8'hC3, 1'b0}, 9, 16);
		line.hold(1'b0, 9);
		line.hold(1'b1, 8);
		settle();
		`CHK(errorIrq, 1'b1)
		// Data read with no status read before it must not clear anything
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'hC3);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h22);
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'hC3);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h00);
		`CHK(errorIrq, 1'b0)
	endtask : scnFrame

	task automatic scnParity;
		wr(sci_rx_pkg::ADDR_RX_CONFIG, 8'h05);
		wr(sci_rx_pkg::ADDR_CONTROL_THR, 8'h01);
		line.send({2'b10, 8'h01, 1'b0}, 11, 16);
		settle();
		`CHK(errorIrq, 1'b1)
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h21);
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'h01);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h00);
		`CHK(errorIrq, 1'b0)
		// Same frame under odd parity is clean
		wr(sci_rx_pkg::ADDR_RX_CONFIG, 8'h0D);
		line.send({2'b10, 8'h01, 1'b0}, 11, 16);
		settle();
		`CHK(errorIrq, 1'b0)
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h20);
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'h01);
		wr(sci_rx_pkg::ADDR_CONTROL_THR, 8'h00);
	endtask : scnParity

	task automatic scnBreak;
		wr(sci_rx_pkg::ADDR_RX_CONFIG, 8'h03);
		line.send({2'b11, 8'h00, 1'b0}, 11, 16);
		settle();
		rc(sci_rx_pkg::ADDR_CONTROL_THR, 8'h80);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h20);
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'h00);
		line.hold(1'b0, 176);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h03);
		rc(sci_rx_pkg::ADDR_STATUS_ONE, 8'h22);
		rc(sci_rx_pkg::ADDR_CONTROL_THR, 8'h00);
		`CHK({irq, errorIrq}, 2'b00)
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'h00);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h01);
		// Line never goes high, so a second all-zero frame is no new break
		line.hold(1'b0, 176);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h01);
		line.hold(1'b1, 170);
		line.hold(1'b0, 176);
		rc(sci_rx_pkg::ADDR_STATUS_TWO, 8'h03);
		line.hold(1'b1, 170);
		wr(sci_rx_pkg::ADDR_RX_CONFIG, 8'h01);
	endtask : scnBreak

	task automatic scnBaud;
		logic [7:0] rsv [7];
		int         cyc [7];
		rsv = '{8'h20, 8'h28, 8'h30, 8'h38, 8'h22, 8'h27, 8'h00};
		cyc = '{16, 48, 64, 208, 64, 2048, 32};
		for (int i = 0; i < 7; i++) begin
			wr(sci_rx_pkg::ADDR_RATE_SELECT, rsv[i]);
			// Divider only restarts at its wrap, so let the old count run out
			line.hold(1'b1, 3000);
			line.send({1'b1, 8'(8'h96 + i), 1'b0}, 10, cyc[i]);
			line.hold(1'b1, cyc[i]);
			rc(sci_rx_pkg::ADDR_DATA_BUF, 8'(8'h96 + i));
		end
	endtask : scnBaud

	task automatic scnResetKeep;
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		`CHK(txData, 8'hA5)
		rc(sci_rx_pkg::ADDR_DATA_BUF, 8'h9C);
		rc(sci_rx_pkg::ADDR_RATE_SELECT, 8'h00);
	endtask : scnResetKeep

	// ********************
	// Main sequence and watchdog
	// ********************
	initial begin
		errCount = 0;
		nTests = 0;
		sys_rst = 1'b1;
		regAddr = 8'h00;
		wrData = 8'h00;
		wrEn = 1'b0;
		rdEn = 1'b0;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		scnReset();
		scnTx();
		scnGood();
		scnFrame();
		scnParity();
		scnBreak();
		scnBaud();
		scnResetKeep();
		completeRun();
	end

	initial begin
		repeat (100000) @(posedge clk_sys);
		errCount++;
		completeRun();
	end
endmodule : sci_rx_flags_and_baud_gen_bench
